// ---- seg_pkg.sv ----
// State-enable register bank: shared constants, types and field layout.
// Assumes a 64-bit hart with machine, supervisor and hypervisor levels.
// How it works
// R01 - Four 64-bit machine state-enable registers, numbered 0 to 3.
// R02 - Four supervisor state-enable registers when supervisor mode exists.
// R03 - Four hypervisor state-enable registers when hypervisor exists.
// R04 - On 32-bit harts machine and hypervisor registers get high halves.
// R05 - Supervisor registers have no high half; upper bits stay zero.
// R06 - Enables gate only less-privileged modes, never the owning level.
// R07 - Blocked access from a lower mode raises illegal instruction.
// R08 - Blocked access from virtual modes may raise virtual instruction.
// R09 - Feature absent means no extra gating of any state.
// R10 - Supervisor bits gate user and virtual user access.
// R11 - Supervisor bits repeat in machine registers, gating all lower modes.
// R12 - Machine bits encroaching from the top read zero in supervisor.
// R13 - Hypervisor layout equals machine; gates virtual modes only.
// R14 - Standard bits write any, read legal; may be fixed zero or one.
// R15 - Unimplemented and reserved bits read zero and ignore writes.
// R16 - Zero machine bit reads as zero in hypervisor and supervisor.
// R17 - Zero hypervisor bit reads zero in supervisor from virtual mode.
// R18 - Lower bit fixed one only where all higher bits fixed one.
// R19 - Reset clears every writable machine bit.
// R20 - Machine software clears lower registers after enabling bits.
// R21 - Bit 63 gates access to the lower-level registers of same number.
// R22 - Machine bit 63 fixed zero only without hypervisor and zero sup.
// R23 - Hypervisor bit 63 is always writable.
// R24 - Read value combines stored bit with the higher-level bits.
package seg_pkg;
   localparam int NREG = 4;
   localparam int XLEN = 64;
   // Register address: level in [3:2], number in [1:0]
   localparam logic [1:0] LVL_M = 2'h0;
   localparam logic [1:0] LVL_S = 2'h1;
   localparam logic [1:0] LVL_H = 2'h2;
   localparam logic [1:0] LVL_MH = 2'h3; // High halves, 32-bit hart
   localparam int ADDR_W = 5; // [4] selects hypervisor high half
   localparam int BIT_SE = 63;
   // Writable bit masks (others read zero); bit 63 writable in machine and hypervisor masks only
   localparam logic [63:0] M_WMASK = 64'hFE00_0000_0000_0007;
   localparam logic [63:0] H_WMASK = 64'hFE00_0000_0000_0007;
   localparam logic [63:0] S_WMASK = 64'h0000_0000_0000_0007;
   // No bit is fixed at one, so no lower bit can be fixed one either
   localparam logic [63:0] M_RO1 = 64'h0000_0000_0000_0000; // R18 R22
   localparam logic [63:0] RST_VAL = 64'h0000_0000_0000_0000;
   typedef enum logic [2:0]
   {
      SEG_PRV_U = 3'h0, SEG_PRV_S = 3'h1, SEG_PRV_M = 3'h3,
      SEG_PRV_VU = 3'h4, SEG_PRV_VS = 3'h5
   } seg_prv_e;
   typedef struct packed
   {
      logic [NREG-1:0][63:0] m; // R01
      logic [NREG-1:0][63:0] h;
      logic [NREG-1:0][63:0] s;
      logic [63:0] rdata;
      logic        err;
   } seg_state_s;
   typedef struct packed
   {
      logic        valid;
      logic [1:0]  num;     // Register number 0-3
      logic [5:0]  bit_idx; // Enable bit guarding the state
      logic        is_csr;  // Access targets a lower stateen register
   } seg_chk_s;
endpackage : seg_pkg

// ---- seg_bank.sv ----
// State-enable register bank with access check for extension state.
// Assumes the core supplies current privilege and virtualisation.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module seg_bank
   import seg_pkg::*;
#(
   parameter bit HAS_S = 1'b1,
   parameter bit HAS_H = 1'b1,
   parameter bit HAS_FEATURE = 1'b1,
   parameter bit IS_32 = 1'b0
)
(
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_b,
   // Register port
   input  wire logic [ADDR_W-1:0]   addr,
   input  wire logic [63:0]         wdata,
   input  wire logic                wr_stb,
   input  wire logic                rd_stb,
   input  wire seg_pkg::seg_prv_e   prv,
   output logic [63:0]              rdata,
   output logic                     acc_err,
   // Access check
   input  wire seg_pkg::seg_chk_s   chk,
   input  wire logic                virt_ok,
   output logic                     illegal_instr,
   output logic                     virtual_instr
);
   import seg_pkg::*;

   seg_state_s st_reg;
   seg_state_s st_next;

   // Effective lower-level value seen from a privilege mode
   function automatic logic [63:0] eff_s(input seg_state_s s,
      input logic [1:0] n, input logic virt);
      logic [63:0] v;
      v = s.s[n] & S_WMASK & s.m[n]; // R16 R12 R24
      if (virt && HAS_H)
         v = v & s.h[n]; // R17
      return HAS_S ? v : 64'h0; // R02
   endfunction : eff_s

   function automatic logic [63:0] eff_h(input seg_state_s s,
      input logic [1:0] n);
      return HAS_H ? (s.h[n] & H_WMASK & s.m[n]) : 64'h0; // R03 R13 R16
   endfunction : eff_h

   logic        virt;
   logic [1:0]  lvl;
   logic [1:0]  num;
   logic        hi;
   logic        blk;
   logic [63:0] mval;
   logic [63:0] wfull;
   assign virt = prv[2];
   assign lvl  = addr[3:2];
   assign num  = addr[1:0];
   assign hi   = addr[4];

   // Register access: decode, privilege and bit-63 gating, write update
   always_comb
   begin
      st_next = st_reg;
      st_next.rdata = 64'h0;
      st_next.err = 1'b0;
      blk = 1'b0;
      mval = 64'h0;
      wfull = wdata;
      unique case (lvl)
         LVL_M, LVL_MH:
         begin
            blk = (prv != SEG_PRV_M) || (lvl == LVL_MH && !IS_32); // R06 R04
            mval = (st_reg.m[num] & M_WMASK) | M_RO1; // R14
            if (IS_32)
               mval = (lvl == LVL_MH) ? {32'h0, mval[63:32]}
                                      : {32'h0, mval[31:0]}; // R04
         end
         LVL_H:
         begin
            blk = !HAS_H || virt || prv == SEG_PRV_U
               || (prv == SEG_PRV_S && !st_reg.m[num][BIT_SE]); // R21
            blk = blk || (hi && !IS_32);
            mval = eff_h(st_reg, num);
            if (IS_32)
               mval = hi ? {32'h0, mval[63:32]} : {32'h0, mval[31:0]};
         end
         LVL_S:
         begin
            blk = !HAS_S || hi || prv == SEG_PRV_U || prv == SEG_PRV_VU
               || (prv != SEG_PRV_M && !st_reg.m[num][BIT_SE])
               || (prv == SEG_PRV_VS && !st_reg.h[num][BIT_SE]); // R21
            mval = eff_s(st_reg, num, virt);
            if (IS_32)
               mval = {32'h0, mval[31:0]}; // R05
         end
      endcase
      if (rd_stb)
      begin
         st_next.err = blk;
         st_next.rdata = blk ? 64'h0 : mval;
      end
      if (wr_stb && !blk)
      begin
         if (IS_32)
            wfull = {32'h0, wdata[31:0]};
         unique case (lvl)
            LVL_M:
               st_next.m[num] = IS_32 ? {st_reg.m[num][63:32], wdata[31:0]}
                                      : wdata & M_WMASK; // R14 R15
            LVL_MH:
               st_next.m[num] = {wdata[31:0], st_reg.m[num][31:0]} & M_WMASK;
            LVL_H:
               if (!IS_32)
                  st_next.h[num] = wdata & H_WMASK; // R23
               else if (hi)
                  st_next.h[num] = {wdata[31:0], st_reg.h[num][31:0]}
                                   & H_WMASK;
               else
                  st_next.h[num] = {st_reg.h[num][63:32], wdata[31:0]}
                                   & H_WMASK;
            LVL_S:
               // Bits masked by higher levels keep their stored value
               st_next.s[num] = (wfull & S_WMASK & eff_mask(virt, num))
                  | (st_reg.s[num] & ~eff_mask(virt, num));
         endcase
      end
      if (wr_stb && blk)
         st_next.err = 1'b1;
      st_next.m[num] = st_next.m[num] & M_WMASK;
   end

   // Bits of the supervisor register that the caller may change
   function automatic logic [63:0] eff_mask(input logic v,
      input logic [1:0] n);
      logic [63:0] hm;
      hm = (v && HAS_H) ? st_reg.h[n] : 64'hFFFF_FFFF_FFFF_FFFF;
      return st_reg.m[n] & hm;
   endfunction : eff_mask

   // State register, synchronous active-low reset
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         st_reg.m     <= '0; // R19
         st_reg.h     <= '0;
         st_reg.s     <= '0;
         st_reg.rdata <= 64'h0;
         st_reg.err   <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   assign rdata   = st_reg.rdata;
   assign acc_err = st_reg.err;

   // Extension-state access check
   logic ok_m;
   logic ok_h;
   logic ok_s;
   logic chk_blk;
   always_comb
   begin
      ok_m = st_reg.m[chk.num][chk.bit_idx]; // R11
      ok_h = !HAS_H || st_reg.h[chk.num][chk.bit_idx]; // R13
      ok_s = !HAS_S || (chk.bit_idx < 6'd32
                        && st_reg.s[chk.num][chk.bit_idx]); // R10 R12
      unique case (prv)
         SEG_PRV_M:  chk_blk = 1'b0; // R06
         SEG_PRV_S:  chk_blk = !ok_m;
         SEG_PRV_U:  chk_blk = !ok_m || !ok_s;
         SEG_PRV_VS: chk_blk = !ok_m || !ok_h;
         SEG_PRV_VU: chk_blk = !ok_m || !ok_h || !ok_s;
         default:    chk_blk = !ok_m;
      endcase
      if (!HAS_FEATURE || !chk.valid)
         chk_blk = 1'b0; // R09
   end

   assign illegal_instr = chk_blk && !(virt && virt_ok && ok_m); // R07
   assign virtual_instr = chk_blk && virt && virt_ok && ok_m; // R08

   // Checks
   mreset_clr_a: assert property (@(posedge clk_sys) // R19
      !rst_b |=> st_reg.m == '0) else $error("machine bank not cleared");
   lowmode_blk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_stb && lvl == LVL_M && prv != SEG_PRV_M |=> acc_err) // R06
      else $error("machine read from lower mode not refused");
   mzero_s_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_stb && lvl == LVL_S && prv == SEG_PRV_M && !IS_32
      |=> (rdata & ~$past(st_reg.m[num])) == 64'h0) // R16
      else $error("supervisor bit visible with machine bit zero");
   hzero_vs_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_stb && lvl == LVL_S && prv == SEG_PRV_VS && !IS_32
      |=> (rdata & ~$past(st_reg.h[num])) == 64'h0) // R17
      else $error("supervisor bit visible with hypervisor bit zero");
   rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st_reg.m[num] & ~M_WMASK) == 64'h0
      && (st_reg.s[num] & ~S_WMASK) == 64'h0) // R15
      else $error("reserved bit stored");
   se63_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      rd_stb && lvl == LVL_H && prv == SEG_PRV_S
      && !st_reg.m[num][BIT_SE] |=> acc_err && rdata == 64'h0) // R21
      else $error("hypervisor register reached with bit 63 clear");
   h63_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_stb && lvl == LVL_H && prv == SEG_PRV_M && HAS_H && !IS_32
      |=> st_reg.h[$past(num)][BIT_SE] == $past(wdata[BIT_SE])) // R23
      else $error("hypervisor bit 63 not writable");
   mmode_free_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      prv == SEG_PRV_M |-> !illegal_instr && !virtual_instr) // R06
      else $error("machine mode blocked");
   user_blk_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      HAS_FEATURE && chk.valid && prv == SEG_PRV_U
      && !st_reg.m[chk.num][chk.bit_idx] |-> illegal_instr) // R07
      else $error("user access not trapped");
   virt_trap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      virtual_instr |-> virt && !illegal_instr) // R08
      else $error("virtual trap outside virtual mode");
   cov_mwrite: cover property (@(posedge clk_sys)
      wr_stb && lvl == LVL_M && prv == SEG_PRV_M);
   cov_vtrap: cover property (@(posedge clk_sys) virtual_instr);
   cov_itrap: cover property (@(posedge clk_sys) illegal_instr);
   cov_sread: cover property (@(posedge clk_sys)
      rd_stb && lvl == LVL_S ##1 !acc_err);
endmodule : seg_bank

// ---- seg_bank_tb.sv ----
// Testbench for the state-enable register bank: register and trap checks.
// Assumes a 64-bit hart with supervisor and hypervisor levels present.
`timescale 1ns/1ps
module tb;
   import seg_pkg::*;
   logic              clk_sys;
   logic              rst_b;
   logic [ADDR_W-1:0] addr;
   logic [63:0]       wdata;
   logic              wr_stb;
   logic              rd_stb;
   seg_prv_e          prv;
   logic [63:0]       rdata;
   logic              acc_err;
   seg_chk_s          chk;
   logic              virt_ok;
   logic              illegal_instr;
   logic              virtual_instr;
   int                n_errors;
   int                samples_checked;
   localparam logic [63:0] ONES = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] B63  = 64'h8000_0000_0000_0000;

   // Device under test with default levels present
   seg_bank uut (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
      .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .prv(prv),
      .rdata(rdata), .acc_err(acc_err), .chk(chk), .virt_ok(virt_ok),
      .illegal_instr(illegal_instr), .virtual_instr(virtual_instr));

   // 25 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Compare one result and count it
   task automatic cmp(input string what, input logic [64:0] exp,
                      input logic [64:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp

   // One strobe; error flag and read data land in the following cycle
   task automatic acc(input logic w, input logic [1:0] lvl,
      input logic [1:0] n, input seg_prv_e p, input logic [63:0] d,
      input logic e, input logic [63:0] x);
      @(posedge clk_sys);
      addr   <= {1'b0, lvl, n};
      wdata  <= d;
      prv    <= p;
      wr_stb <= w;
      rd_stb <= ~w;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      #1;
      cmp($sformatf("reg %0d.%0d", lvl, n), {e, x}, {acc_err, rdata});
   endtask : acc

   task automatic wr(input logic [1:0] lvl, input logic [1:0] n,
      input seg_prv_e p, input logic [63:0] d, input logic e);
      acc(1'b1, lvl, n, p, d, e, 64'h0);
   endtask : wr

   task automatic rd(input logic [1:0] lvl, input logic [1:0] n,
      input seg_prv_e p, input logic e, input logic [63:0] x);
      acc(1'b0, lvl, n, p, 64'h0, e, x);
   endtask : rd

   // Trap query; answers are combinational, {illegal, virtual}
   task automatic trap(input seg_prv_e p, input logic [1:0] n,
      input logic [5:0] b, input logic v, input logic [1:0] exp);
      @(posedge clk_sys);
      chk     <= '{1'b1, n, b, 1'b0};
      prv     <= p;
      virt_ok <= v;
      #1;
      cmp("trap", {63'h0, exp}, {63'h0, illegal_instr, virtual_instr});
   endtask : trap

   // Counts, verdict and end of run
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test

   // Watchdog against a hung run
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      n_errors++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      n_errors = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      addr = '0;
      wdata = 64'h0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      prv = SEG_PRV_M;
      chk = '0;
      virt_ok = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      for (int i = 0; i < NREG; i++)
      begin
         rd(LVL_M, i[1:0], SEG_PRV_M, 1'b0, 64'h0);
         wr(LVL_M, i[1:0], SEG_PRV_M, ONES, 1'b0);
         rd(LVL_M, i[1:0], SEG_PRV_M, 1'b0, M_WMASK);
         wr(LVL_H, i[1:0], SEG_PRV_S, ONES, 1'b0);
         rd(LVL_H, i[1:0], SEG_PRV_S, 1'b0, H_WMASK);
         rd(LVL_S, i[1:0], SEG_PRV_S, 1'b0, 64'h0);
      end
      $display("test reset_and_masks done");
      rd(LVL_M, 2'h0, SEG_PRV_S, 1'b1, 64'h0);
      wr(LVL_M, 2'h1, SEG_PRV_S, 64'h0, 1'b1);
      rd(LVL_M, 2'h1, SEG_PRV_M, 1'b0, M_WMASK);
      rd(LVL_S, 2'h0, SEG_PRV_U, 1'b1, 64'h0);
      rd(LVL_H, 2'h0, SEG_PRV_VS, 1'b1, 64'h0);
      wr(LVL_S, 2'h0, SEG_PRV_S, ONES, 1'b0);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b0, S_WMASK);
      $display("test privilege done");
      wr(LVL_M, 2'h0, SEG_PRV_M, ~64'h2, 1'b0);
      rd(LVL_H, 2'h0, SEG_PRV_S, 1'b0, H_WMASK & ~64'h2);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b0, 64'h5);
      wr(LVL_M, 2'h0, SEG_PRV_M, ONES, 1'b0);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b0, 64'h7);
      wr(LVL_H, 2'h0, SEG_PRV_S, ~64'h1, 1'b0);
      rd(LVL_S, 2'h0, SEG_PRV_VS, 1'b0, 64'h6);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b0, 64'h7);
      $display("test read_masking done");
      wr(LVL_H, 2'h0, SEG_PRV_S, ~B63, 1'b0);
      rd(LVL_S, 2'h0, SEG_PRV_VS, 1'b1, 64'h0);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b0, 64'h7);
      wr(LVL_M, 2'h0, SEG_PRV_M, ~B63, 1'b0);
      rd(LVL_S, 2'h0, SEG_PRV_S, 1'b1, 64'h0);
      wr(LVL_H, 2'h0, SEG_PRV_S, ONES, 1'b1);
      wr(LVL_M, 2'h0, SEG_PRV_M, ONES, 1'b0);
      rd(LVL_H, 2'h0, SEG_PRV_S, 1'b0, H_WMASK & ~B63);
      $display("test bit63_gate done");
      wr(LVL_S, 2'h2, SEG_PRV_S, 64'h1, 1'b0);
      trap(SEG_PRV_M, 2'h2, 6'h1, 1'b1, 2'b00);
      trap(SEG_PRV_U, 2'h2, 6'h0, 1'b1, 2'b00);
      trap(SEG_PRV_U, 2'h2, 6'h1, 1'b1, 2'b10);
      trap(SEG_PRV_VU, 2'h2, 6'h1, 1'b1, 2'b01);
      trap(SEG_PRV_VU, 2'h2, 6'h1, 1'b0, 2'b10);
      trap(SEG_PRV_VS, 2'h2, 6'h1, 1'b1, 2'b00);
      trap(SEG_PRV_S, 2'h2, 6'h5, 1'b1, 2'b10);
      wr(LVL_H, 2'h2, SEG_PRV_S, ~64'h1, 1'b0);
      trap(SEG_PRV_VS, 2'h2, 6'h0, 1'b1, 2'b01);
      trap(SEG_PRV_S, 2'h2, 6'h0, 1'b1, 2'b00);
      wr(LVL_M, 2'h2, SEG_PRV_M, ~64'h4, 1'b0);
      trap(SEG_PRV_S, 2'h2, 6'h2, 1'b1, 2'b10);
      trap(SEG_PRV_M, 2'h2, 6'h2, 1'b1, 2'b00);
      $display("test traps done");
      wr(LVL_H, 2'h3, SEG_PRV_M, 64'h0, 1'b0);
      rd(LVL_H, 2'h3, SEG_PRV_M, 1'b0, 64'h0);
      wr(LVL_S, 2'h3, SEG_PRV_M, 64'h0, 1'b0);
      rd(LVL_S, 2'h3, SEG_PRV_M, 1'b0, 64'h0);
      wr(LVL_M, 2'h3, SEG_PRV_M, ~B63, 1'b0);
      rd(LVL_H, 2'h3, SEG_PRV_S, 1'b1, 64'h0);
      $display("test lower_init done");
      finish_test();
   end
endmodule : tb
